// *** rtl/mbh_host_port.sv ***
// Purpose: host bus port with register access and acknowledge chain
// Assumes: strobes and bus asynchronous to clk; two-stage synchronisers
// Notes: channel logic lives outside; its status arrives on plain ports
`timescale 1ns/1ps
module mbh_host_port #(
   parameter int unsigned RESET_CYC = mbh_pkg::RESET_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic addr_strobe_n,
   input wire logic data_strobe_n,
   input wire logic chip_sel_latched_n,
   input wire logic chip_sel_qualify,
   input wire logic rd_wr,
   input wire logic irq_ack_n,
   input wire logic chain_enable_in,
   input wire logic [7:0] mux_bus_in,
   output logic [7:0] mux_bus_out,
   output logic mux_bus_oe,
   output logic chain_enable_out,
   input wire logic [5:0] irq_pending_bits,
   input wire logic [7:0] buffer_ext_status_a,
   input wire logic [7:0] buffer_ext_status_b,
   input wire logic [7:0] special_rx_status_a,
   input wire logic [7:0] special_rx_status_b,
   input wire logic [7:0] rx_buffer_a,
   input wire logic [7:0] rx_buffer_b,
   input wire logic [7:0] misc_status_a,
   input wire logic [7:0] misc_status_b,
   input wire logic rx_read_a,
   output logic [5:0] under_service_latch,
   output logic [7:0] tx_buffer_a,
   output logic [7:0] tx_buffer_b,
   output logic tx_load_a,
   output logic tx_load_b,
   output logic [7:0] master_irq_ctrl,
   output logic [7:0] shared_vector,
   output logic [15:0] divisor_a,
   output logic [15:0] divisor_b,
   output logic dev_reset
);
   if (RESET_CYC < 1 || RESET_CYC > 255)
   begin
      $error("reset width count out of range");
   end
   // ***********************************
   // synchronisers
   // ***********************************
   // bus and selects are multi-bit but stand still around the strobe edges
   logic [1:0] astb_sync_reg;
   logic [1:0] dstb_sync_reg;
   logic [1:0] chain_in_sync_reg;
   logic [7:0] bus_s1_reg;
   logic [7:0] bus_s2_reg;
   logic [3:0] ctl_s1_reg;
   logic [3:0] ctl_s2_reg;
   always_ff @(posedge clk)
   begin
      astb_sync_reg <= {astb_sync_reg[0], addr_strobe_n};
      dstb_sync_reg <= {dstb_sync_reg[0], data_strobe_n};
      chain_in_sync_reg <= {chain_in_sync_reg[0], chain_enable_in};
      bus_s1_reg <= mux_bus_in;
      bus_s2_reg <= bus_s1_reg;
      ctl_s1_reg <= {chip_sel_latched_n, chip_sel_qualify, rd_wr, irq_ack_n};
      ctl_s2_reg <= ctl_s1_reg;
   end
   wire astb_n = astb_sync_reg[1];
   wire dstb_n = dstb_sync_reg[1];
   wire chain_in_s = chain_in_sync_reg[1];
   wire sel_latch_n_s = ctl_s2_reg[3];
   wire sel_qual_s = ctl_s2_reg[2];
   wire rw_s = ctl_s2_reg[1];
   wire ack_n_s = ctl_s2_reg[0];
   logic astb_prev_reg;
   logic dstb_prev_reg;
   always_ff @(posedge clk)
   begin
      astb_prev_reg <= astb_n;
      dstb_prev_reg <= dstb_n;
   end
   // bus and selects go through the same depth, so they line up with the strobe edge
   wire astb_rise = astb_n && !astb_prev_reg;
   wire dstb_fall = !dstb_n && dstb_prev_reg;
   wire dstb_rise = dstb_n && !dstb_prev_reg;
   // ***********************************
   // reset detect
   // ***********************************
   logic [7:0] rst_cnt_reg;
   logic [7:0] rst_cnt_next;
   logic dev_reset_reg;
   wire both_low = !astb_n && !dstb_n;
   assign rst_cnt_next = !both_low ? 8'h00 :
      (rst_cnt_reg == 8'(RESET_CYC)) ? rst_cnt_reg : rst_cnt_reg + 8'h01;
   wire hw_reset = rst || (rst_cnt_next == 8'(RESET_CYC));
   always_ff @(posedge clk)
   begin
      if (rst)
         rst_cnt_reg <= 8'h00;
      else
         rst_cnt_reg <= rst_cnt_next;
      dev_reset_reg <= hw_reset;
   end
   assign dev_reset = dev_reset_reg;
   // ***********************************
   // address capture and cycle type
   // ***********************************
   logic [7:0] addr_reg;
   logic sel_latch_n_reg;
   logic ack_n_reg;
   logic shift_left_reg;
   mbh_pkg::mbh_state_t state_reg;
   mbh_pkg::mbh_state_t state_next;
   always_ff @(posedge clk)
   begin
      if (hw_reset)
      begin
         addr_reg <= mbh_pkg::RESET_BYTE;
         sel_latch_n_reg <= 1'b1;
         ack_n_reg <= 1'b1;
      end
      else if (astb_rise)
      begin
         addr_reg <= bus_s2_reg;
         sel_latch_n_reg <= sel_latch_n_s;
         ack_n_reg <= ack_n_s;
      end
   end
   wire is_ack = !ack_n_reg;
   wire [3:0] reg_num = addr_reg[mbh_pkg::REG_MSB:mbh_pkg::REG_LSB];
   wire chan_a = shift_left_reg ? addr_reg[mbh_pkg::CHAN_BIT_LEFT]
      : addr_reg[mbh_pkg::CHAN_BIT_RIGHT];
   wire sel_ok = !is_ack && !sel_latch_n_reg && sel_qual_s;
   wire rd_ok = sel_ok && rw_s;
   wire wr_ok = sel_ok && !rw_s;
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         mbh_pkg::MBH_IDLE:
            if (astb_rise)
               state_next = mbh_pkg::MBH_ADDR;
         mbh_pkg::MBH_ADDR:
            if (dstb_fall)
               state_next = mbh_pkg::MBH_DATA;
         mbh_pkg::MBH_DATA:
            if (dstb_rise)
               state_next = mbh_pkg::MBH_IDLE;
         // the fourth code is unused; fall back to idle
         default:
            state_next = mbh_pkg::MBH_IDLE;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (hw_reset)
         state_reg <= mbh_pkg::MBH_IDLE;
      else
         state_reg <= state_next;
   end
   wire strobe = state_reg == mbh_pkg::MBH_ADDR && dstb_fall;
   wire wr_strobe = strobe && wr_ok;
   // ***********************************
   // write registers
   // ***********************************
   logic [7:0] cfg_a_reg [16];
   logic [7:0] cfg_b_reg [16];
   logic [7:0] vec_reg;
   logic [7:0] mic_reg;
   always_ff @(posedge clk)
   begin
      if (hw_reset)
      begin
         for (int i = 0; i < 16; i++)
         begin
            cfg_a_reg[i] <= mbh_pkg::RESET_BYTE;
            cfg_b_reg[i] <= mbh_pkg::RESET_BYTE;
         end
         vec_reg <= mbh_pkg::RESET_BYTE;
         mic_reg <= mbh_pkg::RESET_BYTE;
         shift_left_reg <= 1'b0;
      end
      else if (wr_strobe)
      begin
         if (reg_num == mbh_pkg::RN_2)
            vec_reg <= bus_s2_reg;
         else if (reg_num == mbh_pkg::RN_9)
            mic_reg <= bus_s2_reg;
         else if (chan_a)
            cfg_a_reg[reg_num] <= bus_s2_reg;
         else
            cfg_b_reg[reg_num] <= bus_s2_reg;
         // shift mode command: values 2/3 of the command field on channel B
         if (reg_num == mbh_pkg::RN_0 && !chan_a && bus_s2_reg[7:6] == 2'b00
            && bus_s2_reg[5:3] == 3'b000 && bus_s2_reg[1])
            shift_left_reg <= !bus_s2_reg[0];
      end
   end
   logic tx_load_a_reg;
   logic tx_load_b_reg;
   always_ff @(posedge clk)
   begin
      tx_load_a_reg <= wr_strobe && reg_num == mbh_pkg::RN_8 && chan_a;
      tx_load_b_reg <= wr_strobe && reg_num == mbh_pkg::RN_8 && !chan_a;
   end
   assign tx_buffer_a = cfg_a_reg[mbh_pkg::RN_8];
   assign tx_buffer_b = cfg_b_reg[mbh_pkg::RN_8];
   assign tx_load_a = tx_load_a_reg;
   assign tx_load_b = tx_load_b_reg;
   assign master_irq_ctrl = mic_reg;
   assign shared_vector = vec_reg;
   assign divisor_a = {cfg_a_reg[mbh_pkg::RN_13], cfg_a_reg[mbh_pkg::RN_12]};
   assign divisor_b = {cfg_b_reg[mbh_pkg::RN_13], cfg_b_reg[mbh_pkg::RN_12]};
   // ***********************************
   // read selection
   // ***********************************
   logic [2:0] top_src;
   logic top_found;
   // highest pending index wins; a found flag, since any index may be the answer
   always_comb
   begin
      top_src = 3'b000;
      top_found = 1'b0;
      for (int k = 5; k >= 0; k--)
         if (irq_pending_bits[k] && !top_found)
         begin
            top_src = 3'(k);
            top_found = 1'b1;
         end
   end
   wire any_pending = |irq_pending_bits && mic_reg[mbh_pkg::MIC_MIE];
   // status field sits high or low in the vector per the control bit
   wire [7:0] vec_mod = mic_reg[mbh_pkg::MIC_STATUS_HIGH]
      ? {vec_reg[7], top_src[0], top_src[1], top_src[2], vec_reg[3:0]}
      : {vec_reg[7:4], top_src, vec_reg[0]};
   wire [7:0] rd_a =
      reg_num == mbh_pkg::RN_0 ? buffer_ext_status_a :
      reg_num == mbh_pkg::RN_1 ? special_rx_status_a :
      reg_num == mbh_pkg::RN_2 ? vec_reg :
      reg_num == mbh_pkg::RN_3 ? {2'b00, irq_pending_bits} :
      reg_num == mbh_pkg::RN_8 ? rx_buffer_a :
      reg_num == mbh_pkg::RN_10 ? misc_status_a :
      reg_num == mbh_pkg::RN_12 ? cfg_a_reg[mbh_pkg::RN_12] :
      reg_num == mbh_pkg::RN_13 ? cfg_a_reg[mbh_pkg::RN_13] :
      reg_num == mbh_pkg::RN_15 ? cfg_a_reg[mbh_pkg::RN_15] : 8'h00;
   wire [7:0] rd_b =
      reg_num == mbh_pkg::RN_0 ? buffer_ext_status_b :
      reg_num == mbh_pkg::RN_1 ? special_rx_status_b :
      reg_num == mbh_pkg::RN_2 ? vec_mod :
      reg_num == mbh_pkg::RN_8 ? rx_buffer_b :
      reg_num == mbh_pkg::RN_10 ? misc_status_b :
      reg_num == mbh_pkg::RN_12 ? cfg_b_reg[mbh_pkg::RN_12] :
      reg_num == mbh_pkg::RN_13 ? cfg_b_reg[mbh_pkg::RN_13] :
      reg_num == mbh_pkg::RN_15 ? cfg_b_reg[mbh_pkg::RN_15] : 8'h00;
   // ***********************************
   // acknowledge chain and bus drive
   // ***********************************
   wire claim = strobe && is_ack && any_pending && chain_in_s;
   wire [5:0] src_onehot = 6'h01 << top_src;
   logic [5:0] in_service_reg;
   logic drive_reg;
   logic [7:0] dout_reg;
   logic chain_out_reg;
   always_ff @(posedge clk)
   begin
      if (hw_reset)
      begin
         in_service_reg <= 6'h00;
         drive_reg <= 1'b0;
         dout_reg <= 8'h00;
         chain_out_reg <= 1'b0;
      end
      else
      begin
         if (claim)
            in_service_reg <= in_service_reg | src_onehot;
         if (strobe && rd_ok)
         begin
            drive_reg <= 1'b1;
            dout_reg <= chan_a ? rd_a : rd_b;
         end
         else if (claim && mic_reg[mbh_pkg::MIC_VEC_RESP])
         begin
            drive_reg <= 1'b1;
            dout_reg <= vec_mod;
         end
         else if (dstb_n)
            drive_reg <= 1'b0;
         // a serviced source, or a pending one during an acknowledge cycle, blocks lower devices
         chain_out_reg <= chain_in_s && !(|in_service_reg) && !(is_ack && any_pending);
      end
   end
   assign under_service_latch = in_service_reg;
   assign mux_bus_out = dout_reg;
   assign mux_bus_oe = drive_reg;
   assign chain_enable_out = chain_out_reg;
   logic rx_unused;
   assign rx_unused = rx_read_a;
   // ***********************************
   // checks
   // ***********************************
   sequence s_claim;
      claim && mic_reg[mbh_pkg::MIC_VEC_RESP];
   endsequence
   a_drive_release: assert property (@(posedge clk) disable iff (rst)
      dstb_n && !strobe |=> !mux_bus_oe) else $error("bus driven after strobe");
   a_read_drive: assert property (@(posedge clk) disable iff (hw_reset)
      strobe && rd_ok |=> mux_bus_oe) else $error("read not driven");
   a_vector_drive: assert property (@(posedge clk) disable iff (hw_reset)
      s_claim |=> mux_bus_oe && mux_bus_out == $past(vec_mod)) else $error("no vector");
   a_service_set: assert property (@(posedge clk) disable iff (hw_reset)
      claim |=> |(in_service_reg & $past(src_onehot))) else $error("service not set");
   a_no_ack_write: assert property (@(posedge clk) disable iff (hw_reset)
      is_ack |-> !wr_strobe) else $error("write in acknowledge");
   a_claim_cond: assert property (@(posedge clk) disable iff (hw_reset)
      claim |-> chain_in_s && |irq_pending_bits) else $error("bad claim");
   a_reset_det: assert property (@(posedge clk) disable iff (rst)
      rst_cnt_reg == 8'(RESET_CYC - 1) && both_low |=> dev_reset) else $error("no reset");
   a_write_store: assert property (@(posedge clk) disable iff (hw_reset)
      wr_strobe && reg_num == mbh_pkg::RN_2 |=> vec_reg == $past(bus_s2_reg))
      else $error("vector not stored");
endmodule

// *** include/mbh_pkg.sv ***
// Purpose: shared constants for the multiplexed bus host port
// Assumes: 125 MHz clock
// Notes: register numbers follow the four-bit register field
package mbh_pkg;
   localparam int unsigned CLK_PERIOD_NS = 8;
   // ***********************************
   // strobe timing
   // ***********************************
   localparam int unsigned RESET_WIDTH_NS = 250;
   localparam int unsigned RESET_CYCLES = (RESET_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ***********************************
   // address field layout
   // ***********************************
   localparam int unsigned REG_LSB = 1;
   localparam int unsigned REG_MSB = 4;
   localparam int unsigned CHAN_BIT_RIGHT = 0;
   localparam int unsigned CHAN_BIT_LEFT = 5;
   // ***********************************
   // register numbers
   // ***********************************
   localparam logic [3:0] RN_0 = 4'h0;
   localparam logic [3:0] RN_1 = 4'h1;
   localparam logic [3:0] RN_2 = 4'h2;
   localparam logic [3:0] RN_3 = 4'h3;
   localparam logic [3:0] RN_8 = 4'h8;
   localparam logic [3:0] RN_9 = 4'h9;
   localparam logic [3:0] RN_10 = 4'hA;
   localparam logic [3:0] RN_12 = 4'hC;
   localparam logic [3:0] RN_13 = 4'hD;
   localparam logic [3:0] RN_15 = 4'hF;
   // ***********************************
   // control bit positions
   // ***********************************
   localparam int unsigned MIC_VEC_RESP = 1;
   localparam int unsigned MIC_STATUS_HIGH = 4;
   localparam int unsigned MIC_MIE = 3;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   typedef enum logic [1:0] {MBH_IDLE, MBH_ADDR, MBH_DATA} mbh_state_t;
endpackage

// *** test/mbh_host_model.sv ***
// Purpose: processor model driving the multiplexed address/data bus
// Assumes: one transfer at a time; pins change only after rising clk
// Notes: released bus lines toggle every cycle, so stale data never reads back
`timescale 1ns/1ps
module mbh_host_model (
   input wire logic clk,
   input wire logic [7:0] mux_bus_out,
   input wire logic mux_bus_oe,
   output logic addr_strobe_n,
   output logic data_strobe_n,
   output logic chip_sel_latched_n,
   output logic chip_sel_qualify,
   output logic rd_wr,
   output logic irq_ack_n,
   output logic [7:0] mux_bus_in
);
   // ***********************************
   // bus resolution
   // ***********************************
   localparam int RECOVER_CYC = 6 + 25;
   logic [7:0] drv_reg = 8'h00;
   logic drv_en_reg = 1'b0;
   logic [7:0] idle_reg = 8'h5A;
   assign mux_bus_in = mux_bus_oe ? mux_bus_out : (drv_en_reg ? drv_reg : idle_reg);
   always @(posedge clk) idle_reg <= ~idle_reg;
   initial
   begin
      addr_strobe_n = 1'b1;
      data_strobe_n = 1'b1;
      chip_sel_latched_n = 1'b1;
      chip_sel_qualify = 1'b0;
      rd_wr = 1'b1;
      irq_ack_n = 1'b1;
   end
   // ***********************************
   // bus cycles
   // ***********************************
   task automatic xfer(input logic wr, input logic ack_n, input logic sel_l_n, input logic sel_q,
      input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata,
      output logic got);
      got = 1'b0;
      rdata = 8'h00;
      @(posedge clk);
      drv_reg <= addr;
      drv_en_reg <= 1'b1;
      chip_sel_latched_n <= sel_l_n;
      irq_ack_n <= ack_n;
      addr_strobe_n <= 1'b0;
      rd_wr <= ~wr;
      chip_sel_qualify <= sel_q;
      repeat (3) @(posedge clk);
      addr_strobe_n <= 1'b1;
      repeat (8) @(posedge clk); // chain settle time before data strobe
      drv_reg <= wdata;
      drv_en_reg <= wr;
      data_strobe_n <= 1'b0;
      repeat (12)
      begin
         @(negedge clk);
         if (mux_bus_oe === 1'b1)
         begin
            got = 1'b1;
            rdata = mux_bus_out;
         end
      end
      @(posedge clk);
      data_strobe_n <= 1'b1;
      @(posedge clk);
      drv_en_reg <= 1'b0;
      chip_sel_qualify <= 1'b0;
      irq_ack_n <= 1'b1;
      repeat (RECOVER_CYC) @(posedge clk); // six clocks plus 200 ns
   endtask
   task automatic strobe_reset(input int cyc);
      @(posedge clk);
      addr_strobe_n <= 1'b0; // both strobes low only to reset
      data_strobe_n <= 1'b0;
      repeat (cyc) @(posedge clk);
      addr_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      repeat (RECOVER_CYC) @(posedge clk);
   endtask
endmodule

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the multiplexed bus host port
// Assumes: shift right addressing after reset; short strobe reset count
// Notes: pending sources fixed at three and one, so the vector carries index three
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic wr; logic [3:0] rn; logic cha; logic [7:0] val;} mbh_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic chain_in = 1'b0;
   logic [5:0] pend = 6'h0A;
   logic [7:0] stat [8];
   logic astb_n, dstb_n, sel_l_n, sel_q, rw, ack_n, oe, ceo, dres, tla, tlb, got;
   logic [7:0] bin, bout, txa, txb, mic, vec, rdata;
   logic [5:0] in_svc;
   logic [15:0] diva, divb;
   int failures = 0;
   int check_count = 0;
   int tx_pulses = 0;
   logic reset_seen = 1'b0;
   mbh_row_t rows [21] = '{
      {1'h1, 4'hC, 1'h1, 8'h34}, {1'h1, 4'hD, 1'h1, 8'h12}, {1'h1, 4'hC, 1'h0, 8'h78},
      {1'h1, 4'hD, 1'h0, 8'h56}, {1'h1, 4'h2, 1'h0, 8'hA5}, {1'h1, 4'h9, 1'h1, 8'h0A},
      {1'h0, 4'hC, 1'h1, 8'h34}, {1'h0, 4'hD, 1'h1, 8'h12}, {1'h0, 4'hC, 1'h0, 8'h78},
      {1'h0, 4'hD, 1'h0, 8'h56}, {1'h0, 4'h2, 1'h1, 8'hA5}, {1'h0, 4'h0, 1'h1, 8'h11},
      {1'h0, 4'h0, 1'h0, 8'h22}, {1'h0, 4'h1, 1'h1, 8'h33}, {1'h0, 4'h1, 1'h0, 8'h44},
      {1'h0, 4'h8, 1'h1, 8'h55}, {1'h0, 4'h8, 1'h0, 8'h66}, {1'h0, 4'hA, 1'h1, 8'h77},
      {1'h0, 4'hA, 1'h0, 8'h88}, {1'h0, 4'h3, 1'h1, 8'h0A},
      {1'h0, 4'h2, 1'h0, 8'hA7}};
   initial
   begin
      for (int i = 0; i < 8; i++) stat[i] = 8'(8'h11 * (i + 1));
      forever #4 clk = ~clk;
   end
   mbh_host_model mbh_host_model_inst (.clk(clk), .mux_bus_out(bout), .mux_bus_oe(oe),
      .addr_strobe_n(astb_n), .data_strobe_n(dstb_n), .chip_sel_latched_n(sel_l_n),
      .chip_sel_qualify(sel_q), .rd_wr(rw), .irq_ack_n(ack_n), .mux_bus_in(bin));
   // short strobe reset count keeps the run brief
   mbh_host_port #(.RESET_CYC(4)) mbh_host_port_inst (.clk(clk), .rst(rst),
      .addr_strobe_n(astb_n), .data_strobe_n(dstb_n), .chip_sel_latched_n(sel_l_n),
      .chip_sel_qualify(sel_q), .rd_wr(rw), .irq_ack_n(ack_n), .chain_enable_in(chain_in),
      .mux_bus_in(bin), .mux_bus_out(bout), .mux_bus_oe(oe), .chain_enable_out(ceo),
      .irq_pending_bits(pend), .buffer_ext_status_a(stat[0]), .buffer_ext_status_b(stat[1]),
      .special_rx_status_a(stat[2]), .special_rx_status_b(stat[3]), .rx_buffer_a(stat[4]),
      .rx_buffer_b(stat[5]), .misc_status_a(stat[6]), .misc_status_b(stat[7]),
      .rx_read_a(1'b0), .under_service_latch(in_svc), .tx_buffer_a(txa), .tx_buffer_b(txb),
      .tx_load_a(tla), .tx_load_b(tlb), .master_irq_ctrl(mic), .shared_vector(vec),
      .divisor_a(diva), .divisor_b(divb), .dev_reset(dres));
   always @(posedge clk)
   begin
      if (tla === 1'b1 || tlb === 1'b1) tx_pulses <= tx_pulses + 1;
      // only a strobe reset counts; the power-on reset also raises this output
      if (dres === 1'b1 && dstb_n === 1'b0) reset_seen <= 1'b1;
   end
   // ***********************************
   // checks and transfers
   // ***********************************
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic wr, input logic an, input logic c0n, input logic c1,
      input logic [3:0] rn, input logic cha, input logic [7:0] wd);
      mbh_host_model_inst.xfer(wr, an, c0n, c1, {3'h0, rn, cha}, wd, rdata, got);
      chk(16'(oe), 16'h0000); // bus released between transfers
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude;
   end
   // ***********************************
   // main sequence
   // ***********************************
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({oe, ceo, in_svc, vec}, 16'h0000); // idle after reset
      foreach (rows[i])
      begin
         acc(rows[i].wr, 1'b1, 1'b0, 1'b1, rows[i].rn, rows[i].cha, rows[i].val);
         if (rows[i].wr === 1'b0) chk({7'h00, got, rdata}, {8'h01, rows[i].val});
      end
      chk(diva, 16'h1234);
      chk(divb, 16'h5678);
      chk({vec, mic}, 16'hA50A); // shared registers
      mbh_host_model_inst.xfer(1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 8'h02, rdata, got);
      mbh_host_model_inst.xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'hF8, 8'h00, rdata, got);
      chk({7'h00, got, rdata}, 16'h0134); // shift left: bit five picks channel A
      mbh_host_model_inst.xfer(1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 8'h03, rdata, got);
      mbh_host_model_inst.xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'hF8, 8'h00, rdata, got);
      chk({7'h00, got, rdata}, 16'h0178); // shift right: bit zero low picks B
      acc(1'b1, 1'b1, 1'b0, 1'b1, 4'h8, 1'h1, 8'hC9);
      acc(1'b1, 1'b1, 1'b0, 1'b1, 4'h8, 1'h0, 8'h9C);
      chk({txa, txb}, 16'hC99C);
      chk(16'(tx_pulses), 16'h0002); // one load pulse per buffer write
      acc(1'b1, 1'b1, 1'b0, 1'b0, 4'h2, 1'h0, 8'h3C);
      acc(1'b1, 1'b1, 1'b1, 1'b1, 4'h2, 1'h0, 8'h3C);
      chk(16'(vec), 16'h00A5); // refused writes leave vector
      acc(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 1'h1, 8'h00);
      chk(16'(got), 16'h0000); // read without second select
      acc(1'b0, 1'b1, 1'b1, 1'b1, 4'h0, 1'h1, 8'h00);
      chk(16'(got), 16'h0000); // read with first select high
      acc(1'b1, 1'b0, 1'b1, 1'b0, 4'h2, 1'h0, 8'hFF);
      chk({9'h000, got, in_svc}, 16'h0000); // enable-in low, no claim
      chain_in <= 1'b1;
      acc(1'b1, 1'b0, 1'b1, 1'b0, 4'h2, 1'h0, 8'hFF);
      chk({7'h00, got, rdata}, 16'h01A7); // claimed, vector with source three
      chk({9'h000, ceo, in_svc}, 16'h0008); // top source in service, chain shut
      chk(16'(vec), 16'h00A5); // acknowledge write with selects off leaves vector
      mbh_host_model_inst.strobe_reset(8);
      chk({15'h0000, reset_seen}, 16'h0001);
      chk({8'h00, dres, ceo, in_svc}, 16'h0040); // service cleared, chain open
      conclude;
   end
endmodule
